// ---- shared/rtt_pkg.sv ----
// constants for the second general-purpose down-counting timer
// assumes a single 125 MHz clock and an APB register port, 32-bit data
package rtt_pkg;

	// ----------------------------------------------------------------
	// register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CONTROL = 8'h19;
	localparam logic [7:0] IDX_RELOAD_HIGH = 8'h1a;
	localparam logic [7:0] IDX_RELOAD_LOW = 8'h1b;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'h1c;
	localparam logic [7:0] IDX_COUNT_LOW = 8'h1d;
	localparam logic [7:0] IDX_CMD_STATUS = 8'h26;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CTL_STOP_RX_BIT = 7;
	localparam int CTL_START_HI = 5;
	localparam int CTL_START_LO = 4;
	localparam int CTL_AUTO_RELOAD_BIT = 3;
	localparam int CTL_CLK_HI = 1;
	localparam int CTL_CLK_LO = 0;
	localparam logic [7:0] CTL_WRITE_MASK = 8'hbb;

	// ----------------------------------------------------------------
	// command / status register fields
	// ----------------------------------------------------------------
	localparam int CS_FLAG_BIT = 0;
	localparam int CS_RUNNING_BIT = 1;
	localparam int CS_SW_START_BIT = 6;
	localparam int CS_SW_STOP_BIT = 7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_RELOAD = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;

	// ----------------------------------------------------------------
	// encodings and rates
	// ----------------------------------------------------------------
	localparam logic [1:0] START_NONE = 2'b00;
	localparam logic [1:0] START_TX_END = 2'b01;
	localparam logic [1:0] START_TRIM_NO_UF = 2'b10;
	localparam logic [1:0] START_TRIM_UF = 2'b11;
	localparam logic [1:0] CLK_FAST = 2'b00;
	localparam logic [1:0] CLK_SLOW = 2'b01;
	localparam logic [1:0] CLK_FIRST_TIMER = 2'b10;
	localparam logic [1:0] CLK_SECOND_TIMER = 2'b11;

	// rates in kHz; ticks come from a phase accumulator on ref_clk
	localparam logic [17:0] REF_CLK_KHZ = 18'd125000;
	localparam logic [17:0] FAST_TICK_KHZ = 18'd13560;
	localparam logic [17:0] SLOW_TICK_KHZ = 18'd212;

	typedef enum logic [1:0] {
		RTT_IDLE = 2'b00,
		RTT_COUNT = 2'b01
	} rtt_state_t;

endpackage

// ---- rtl/rtt_timer_two.sv ----
// second 16-bit down-counting timer with its APB register slave
// assumes all event inputs are one-cycle pulses synchronous to ref_clk
`timescale 1ns/1ps

// Behaviour
// RULE1 - stop-on-receive set: halt counting after first four received bits
// RULE2 - stop-on-receive ignored in both oscillator trimming modes
// RULE3 - start select 00b: no hardware event starts the timer
// RULE4 - start select 01b: start when an RF transmission finishes
// RULE5 - start select 10b: trimming, start/stop on rising edges, no underflow
// RULE6 - start select 11b: trimming on rising edges, underflow active
// RULE7 - auto-reload set: reload at zero and keep counting down
// RULE8 - auto-reload clear: count to zero, then stay stopped
// RULE9 - every underflow sets the underflow flag
// RULE10 - clock select 00b: decrement at 13.56 MHz
// RULE11 - clock select 01b: decrement at 212 kHz
// RULE12 - clock select 10b: decrement per first timer underflow
// RULE13 - clock select 11b: decrement per second timer underflow
// RULE14 - each start loads full 16-bit reload value from both bytes
// RULE15 - reload writes do not disturb running count; used at next start
// RULE16 - reload high byte at 1Ah, low byte at 1Bh, read-write
// RULE17 - live count readable: high byte 1Ch, low byte 1Dh
// RULE18 - software must not read live count during reception
// RULE19 - control register at 19h; bits 6 and 2 reserved
// RULE20 - decrement one per selected tick; underflow when passing zero
module rtt_timer_two (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_end,
	input wire logic rx_first_nibble,
	input wire logic low_freq_oscillator,
	input wire logic first_timer_underflow,
	input wire logic second_timer_underflow,
	output logic underflow_irq_flag,
	output logic underflow_pulse,
	output logic timer_running
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// phase accumulator step: returns {tick, next accumulator}
	// the sum stays below 2^18 while the step is under the clock rate
	function automatic logic [18:0] acc_step(input logic [17:0] acc,
			input logic [17:0] inc);
		logic [17:0] sum;
		sum = acc + inc;
		if (sum >= rtt_pkg::REF_CLK_KHZ) begin
			acc_step = {1'b1, sum - rtt_pkg::REF_CLK_KHZ};
		end else begin
			acc_step = {1'b0, sum};
		end
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	// register file, live count and sequencing state
	logic [7:0] timer_two_control;
	logic [7:0] timer_two_reload_high;
	logic [7:0] timer_two_reload_low;
	logic [15:0] count;
	rtt_pkg::rtt_state_t state;
	logic [17:0] fast_acc;
	logic [17:0] slow_acc;
	logic fast_tick;
	logic slow_tick;
	logic [18:0] next_fast;
	logic [18:0] next_slow;
	logic lfo_prev;
	logic lfo_rise;
	logic count_tick;
	logic trim_mode;
	logic uf_handling;
	logic hw_start;
	logic hw_stop;
	logic sw_start;
	logic sw_stop;
	logic flag_clear;
	logic bus_access;
	logic bus_write;
	logic [7:0] reg_index;
	logic addr_ok;
	logic [1:0] start_select;
	logic [1:0] count_clock_select;
	logic stop_on_receive;
	logic auto_reload_enable;
	logic at_zero;

	assign start_select = timer_two_control[rtt_pkg::CTL_START_HI:
		rtt_pkg::CTL_START_LO];
	assign count_clock_select = timer_two_control[rtt_pkg::CTL_CLK_HI:
		rtt_pkg::CTL_CLK_LO];
	assign stop_on_receive = timer_two_control[rtt_pkg::CTL_STOP_RX_BIT];
	assign auto_reload_enable =
		timer_two_control[rtt_pkg::CTL_AUTO_RELOAD_BIT];

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// one wait state: pready rises in the second access cycle
	// a write lands only at the edge that samples pready high
	assign bus_access = psel & penable & pready;
	assign bus_write = bus_access & pwrite;
	assign reg_index = paddr[9:2];
	always_comb begin
		case (reg_index)
			rtt_pkg::IDX_CONTROL,
			rtt_pkg::IDX_RELOAD_HIGH,
			rtt_pkg::IDX_RELOAD_LOW,
			rtt_pkg::IDX_COUNT_HIGH,
			rtt_pkg::IDX_COUNT_LOW,
			rtt_pkg::IDX_CMD_STATUS: addr_ok = (paddr[1:0] == 2'b00);
			default: addr_ok = 1'b0;
		endcase
	end

	// command bits are pulses, the flag clear is write-one
	// a software start also reloads a count that is already running
	assign sw_start = bus_write & addr_ok &
		(reg_index == rtt_pkg::IDX_CMD_STATUS) &
		pwdata[rtt_pkg::CS_SW_START_BIT];
	assign sw_stop = bus_write & addr_ok &
		(reg_index == rtt_pkg::IDX_CMD_STATUS) &
		pwdata[rtt_pkg::CS_SW_STOP_BIT];
	assign flag_clear = bus_write & addr_ok &
		(reg_index == rtt_pkg::IDX_CMD_STATUS) &
		pwdata[rtt_pkg::CS_FLAG_BIT];

	// ----------------------------------------------------------------
	// bus handshake and read data
	// ----------------------------------------------------------------
	// read data is registered a cycle ahead, hence the wait state
	// trade-off: one extra cycle per transfer for a flopped prdata
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addr_ok;
			prdata <= 32'h0000_0000;
			if (psel & penable & ~pready & ~pwrite & addr_ok) begin
				case (reg_index)
					rtt_pkg::IDX_CONTROL:
						prdata[7:0] <= timer_two_control; // RULE19
					rtt_pkg::IDX_RELOAD_HIGH:
						prdata[7:0] <= timer_two_reload_high; // RULE16
					rtt_pkg::IDX_RELOAD_LOW:
						prdata[7:0] <= timer_two_reload_low; // RULE16
					rtt_pkg::IDX_COUNT_HIGH:
						prdata[7:0] <= count[15:8]; // RULE17
					rtt_pkg::IDX_COUNT_LOW:
						prdata[7:0] <= count[7:0]; // RULE17
					rtt_pkg::IDX_CMD_STATUS: begin
						prdata[rtt_pkg::CS_FLAG_BIT] <= underflow_irq_flag;
						prdata[rtt_pkg::CS_RUNNING_BIT] <= timer_running;
					end
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	// reserved control bits are masked so they always read zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			timer_two_control <= rtt_pkg::RST_CONTROL;
		end else if (bus_write && addr_ok &&
				reg_index == rtt_pkg::IDX_CONTROL) begin
			timer_two_control <= pwdata[7:0] &
				rtt_pkg::CTL_WRITE_MASK; // RULE19
		end
	end

	// reload bytes only feed the counter at a start event or an auto-reload at zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			timer_two_reload_high <= rtt_pkg::RST_RELOAD;
			timer_two_reload_low <= rtt_pkg::RST_RELOAD;
		end else if (bus_write && addr_ok) begin
			if (reg_index == rtt_pkg::IDX_RELOAD_HIGH) begin
				timer_two_reload_high <= pwdata[7:0]; // RULE16
			end
			if (reg_index == rtt_pkg::IDX_RELOAD_LOW) begin
				timer_two_reload_low <= pwdata[7:0]; // RULE16
			end
		end
	end

	// ----------------------------------------------------------------
	// tick generation
	// ----------------------------------------------------------------
	// fractional accumulators: average rate exact, jitter one cycle
	assign next_fast = acc_step(fast_acc, rtt_pkg::FAST_TICK_KHZ);
	assign next_slow = acc_step(slow_acc, rtt_pkg::SLOW_TICK_KHZ);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fast_acc <= 18'h0_0000;
			slow_acc <= 18'h0_0000;
			fast_tick <= 1'b0;
			slow_tick <= 1'b0;
		end else begin
			fast_acc <= next_fast[17:0];
			slow_acc <= next_slow[17:0];
			fast_tick <= next_fast[18];
			slow_tick <= next_slow[18];
		end
	end

	// input clock selection
	// cascade inputs are single-cycle pulses from the neighbour timers
	always_comb begin
		case (count_clock_select)
			rtt_pkg::CLK_FAST: count_tick = fast_tick; // RULE10
			rtt_pkg::CLK_SLOW: count_tick = slow_tick; // RULE11
			rtt_pkg::CLK_FIRST_TIMER:
				count_tick = first_timer_underflow; // RULE12
			rtt_pkg::CLK_SECOND_TIMER:
				count_tick = second_timer_underflow; // RULE13
			default: count_tick = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// start and stop events
	// ----------------------------------------------------------------
	// reference edge detector; resets low like the idle pin level
	// so that no false rising edge follows reset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lfo_prev <= 1'b0;
		end else begin
			lfo_prev <= low_freq_oscillator;
		end
	end
	assign lfo_rise = low_freq_oscillator & ~lfo_prev;

	// both trimming encodings share the upper start-select bit
	assign trim_mode = start_select[1];
	// trimming without underflow keeps neither flag nor reload
	assign uf_handling =
		(start_select != rtt_pkg::START_TRIM_NO_UF); // RULE5 RULE6

	// 00b starts nothing; 01b on end of transmission; trim on rising edge
	assign hw_start = (state == rtt_pkg::RTT_IDLE) &&
		((start_select == rtt_pkg::START_TX_END && tx_end) || // RULE4 RULE3
		(trim_mode && lfo_rise)); // RULE5 RULE6

	// while running, a stop outranks a tick or a software start in the same cycle
	assign hw_stop = (state == rtt_pkg::RTT_COUNT) &&
		((trim_mode && lfo_rise) || // RULE5 RULE6
		(stop_on_receive && !trim_mode && rx_first_nibble)); // RULE1 RULE2

	// ----------------------------------------------------------------
	// counter state machine
	// ----------------------------------------------------------------
	// underflow is a tick while at zero, so the count never wraps
	assign at_zero = (count == 16'h0000);

	// priority while running: stop, then software start, then tick
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= rtt_pkg::RTT_IDLE;
			count <= rtt_pkg::RST_COUNT;
			underflow_pulse <= 1'b0;
		end else begin
			underflow_pulse <= 1'b0;
			case (state)
				rtt_pkg::RTT_IDLE: begin
					if (sw_start || hw_start) begin
						count <= {timer_two_reload_high,
							timer_two_reload_low}; // RULE14 RULE15
						state <= rtt_pkg::RTT_COUNT;
					end
				end
				rtt_pkg::RTT_COUNT: begin
					if (sw_stop || hw_stop) begin
						state <= rtt_pkg::RTT_IDLE;
					end else if (sw_start) begin
						count <= {timer_two_reload_high,
							timer_two_reload_low}; // RULE14
					end else if (count_tick) begin
						if (!at_zero) begin
							count <= count - 16'h0001; // RULE20
						end else if (!uf_handling) begin
							state <= rtt_pkg::RTT_IDLE; // RULE5
						end else begin
							underflow_pulse <= 1'b1; // RULE20
							if (auto_reload_enable) begin
								count <= {timer_two_reload_high,
									timer_two_reload_low}; // RULE7
							end else begin
								state <= rtt_pkg::RTT_IDLE; // RULE8
							end
						end
					end
				end
				default: state <= rtt_pkg::RTT_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status outputs
	// ----------------------------------------------------------------
	// set wins over a software clear in the same cycle
	// only a tick at zero with underflow handling sets it
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			underflow_irq_flag <= 1'b0;
		end else if (state == rtt_pkg::RTT_COUNT && !sw_stop && !hw_stop &&
				!sw_start && count_tick && at_zero && uf_handling) begin
			underflow_irq_flag <= 1'b1; // RULE9
		end else if (flag_clear) begin
			underflow_irq_flag <= 1'b0;
		end
	end

	// mirrors the state so the output comes from a flop of its own
	// it must follow every branch of the state machine above
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			timer_running <= 1'b0;
		end else begin
			case (state)
				rtt_pkg::RTT_IDLE: timer_running <= sw_start | hw_start;
				rtt_pkg::RTT_COUNT: timer_running <= ~(sw_stop | hw_stop |
					(~sw_start & count_tick & at_zero &
					~(uf_handling & auto_reload_enable)));
				default: timer_running <= 1'b0;
			endcase
		end
	end

endmodule // rtt_timer_two

// ---- test/rtt_timer_two_assertions.sv ----
// checker for the second timer: bus timing and timer events
// assumes it is bound onto rtt_timer_two and sees only its ports
`timescale 1ns/1ps
module rtt_timer_two_assertions (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_end,
	input wire logic rx_first_nibble,
	input wire logic underflow_irq_flag,
	input wire logic underflow_pulse,
	input wire logic timer_running
);
	logic [7:0] ctl;
	logic acc;

	// shadow of the control byte, taken where the slave commits writes
	assign acc = psel && penable && pready;
	always_ff @(posedge ref_clk) begin
		if (srst)
			ctl <= 8'h00;
		else if (acc && pwrite && paddr == 10'h064)
			ctl <= pwdata[7:0];
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	// ----------------------------------------
	// register port
	// ----------------------------------------
	property p_wait;
		psel && !penable ##1 psel && penable |-> !pready ##1 pready;
	endproperty
	a_wait: assert property (p_wait)
		else $error("wait state wrong");
	property p_err;
		acc && !(paddr[9:2] inside {[8'h19:8'h1d], 8'h26}) |-> pslverr;
	endproperty
	a_err: assert property (p_err)
		else $error("unmapped access not refused");
	property p_rsvd;
		acc && !pwrite && paddr == 10'h064 |-> !prdata[6] && !prdata[2];
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved control bit read high");

	// ----------------------------------------
	// timer events; past control used in the underflow checks since a write may land mid-tick
	// ----------------------------------------
	property p_flag;
		underflow_pulse |-> underflow_irq_flag;
	endproperty
	a_flag: assert property (p_flag)
		else $error("underflow without flag");
	property p_tx;
		tx_end && ctl[5:4] == 2'b01 && !timer_running && !psel
			|=> timer_running;
	endproperty
	a_tx: assert property (p_tx)
		else $error("no start at transmit end");
	property p_rx;
		rx_first_nibble && ctl[7] && !ctl[5] && timer_running
			|=> !timer_running;
	endproperty
	a_rx: assert property (p_rx)
		else $error("no stop on receive");
	property p_once;
		underflow_pulse && !$past(ctl[3]) |-> !timer_running;
	endproperty
	a_once: assert property (p_once)
		else $error("kept running without reload");
	property p_again;
		underflow_pulse && $past(ctl[3]) |-> timer_running;
	endproperty
	a_again: assert property (p_again)
		else $error("stopped despite reload");
endmodule // rtt_timer_two_assertions

// ---- test/rtt_timer_two_bench.sv ----
// bench for the second timer: register access and timer events
// assumes the checker module is compiled before this file
`timescale 1ns/1ps
module rtt_timer_two_bench;
	localparam logic [7:0] ctl = rtt_pkg::IDX_CONTROL;
	localparam logic [7:0] rhi = rtt_pkg::IDX_RELOAD_HIGH;
	localparam logic [7:0] rlo = rtt_pkg::IDX_RELOAD_LOW;
	localparam logic [7:0] chi = rtt_pkg::IDX_COUNT_HIGH;
	localparam logic [7:0] clo = rtt_pkg::IDX_COUNT_LOW;
	localparam logic [7:0] st = rtt_pkg::IDX_CMD_STATUS;
	logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [9:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [4:0] ev = '0;
	logic [31:0] prdata;
	logic pready, pslverr, underflow_irq_flag, underflow_pulse;
	logic timer_running;
	logic [17:0] exp_q[$];
	logic [17:0] note;
	int failures = 0, tests_run = 0, seed = 58, n;

	// ev: tx end, rx nibble, trim ref, first and second cascade
	rtt_timer_two u_rtt_timer_two (.ref_clk(ref_clk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_end(ev[0]), .rx_first_nibble(ev[1]),
		.low_freq_oscillator(ev[2]), .first_timer_underflow(ev[3]),
		.second_timer_underflow(ev[4]),
		.underflow_irq_flag(underflow_irq_flag),
		.underflow_pulse(underflow_pulse), .timer_running(timer_running));

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(logic [9:0] a, logic [8:0] e, logic [8:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("FAIL reg %h expected %h seen %h", a, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bail();
		failures++;
		test_done();
	endtask
	// one transfer; request held until ready is seen, bounded
	task automatic xfer(logic w, logic [7:0] idx, logic [7:0] d);
		int i;
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i == 20)
			bail();
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(logic [7:0] idx, logic [7:0] d);
		xfer(1, idx, d);
	endtask
	// note holds mask over {error, byte} and the expected value
	task automatic rd(logic [7:0] idx, logic [8:0] m, logic [8:0] e);
		exp_q.push_back({m, e});
		xfer(0, idx, 8'h00);
	endtask
	task automatic pulse(int b);
		@(posedge ref_clk);
		ev[b] <= 1;
		@(posedge ref_clk);
		ev[b] <= 0;
	endtask
	task automatic wait_uf(int lim);
		int i;
		i = 0;
		while (underflow_pulse !== 1'b1 && i < lim) begin
			@(posedge ref_clk);
			i++;
		end
		if (underflow_pulse !== 1'b1)
			bail();
		@(posedge ref_clk);
	endtask

	// oldest note against each completed read
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			note = exp_q.pop_front();
			check(paddr, note[8:0], {pslverr, prdata[7:0]} & note[17:9]);
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		srst <= 0;
		rd(ctl, 9'h1ff, 9'h000);
		wr(ctl, 8'hff);
		rd(ctl, 9'h1ff, 9'h0bb);
		wr(rhi, 8'ha5);
		rd(rhi, 9'h1ff, 9'h0a5);
		wr(rlo, 8'h5a);
		rd(rlo, 9'h1ff, 9'h05a);
		wr(chi, 8'h77);
		rd(chi, 9'h1ff, 9'h000);
		rd(8'h30, 9'h1ff, 9'h100);
		$display("registers done");
		wr(ctl, 8'h02);
		pulse(0);
		rd(st, 9'h002, 9'h000);
		// cascade from each source; the other source must not tick
		for (int k = 0; k < 2; k++) begin
			n = ($random(seed) & 7) + 2;
			wr(rhi, 8'h00);
			wr(rlo, n[7:0]);
			wr(ctl, 8'h12 + 8'(k));
			pulse(0);
			pulse(4 - k);
			rd(clo, 9'h1ff, 9'(n));
			wr(rlo, 8'hff);
			repeat (n) pulse(3 + k);
			rd(clo, 9'h1ff, 9'h000);
			rd(st, 9'h003, 9'h002);
			pulse(3 + k);
			rd(st, 9'h003, 9'h001);
			wr(st, 8'h01);
		end
		pulse(0);
		rd(clo, 9'h1ff, 9'h0ff);
		wr(st, 8'h80);
		$display("cascade done");
		wr(ctl, 8'h92);
		pulse(0);
		pulse(1);
		rd(st, 9'h002, 9'h000);
		// trim modes: reference edges start and stop, receive ignored
		for (int k = 0; k < 2; k++) begin
			wr(ctl, 8'ha2 + 8'(k << 4));
			pulse(2);
			pulse(1);
			rd(st, 9'h002, 9'h002);
			pulse(2);
			rd(st, 9'h002, 9'h000);
		end
		// trim at zero: 10b just stops, 11b also flags the underflow
		wr(rlo, 8'h00);
		for (int k = 0; k < 2; k++) begin
			wr(ctl, 8'h22 + 8'(k << 4));
			pulse(2);
			pulse(3);
			rd(st, 9'h003, 9'(k));
			wr(st, 8'h01);
		end
		// software start loads the reload value with no hardware event
		wr(rlo, 8'h07);
		wr(ctl, 8'h02);
		wr(st, 8'h40);
		rd(clo, 9'h1ff, 9'h007);
		wr(st, 8'h80);
		$display("receive and trim done");
		wr(rlo, 8'h03);
		wr(ctl, 8'h18);
		pulse(0);
		wait_uf(200);
		rd(st, 9'h003, 9'h003);
		wait_uf(200);
		wr(ctl, 8'h10);
		wait_uf(200);
		rd(st, 9'h003, 9'h001);
		wr(st, 8'h01);
		// slow rate: two ticks cannot pass within 300 cycles
		wr(rlo, 8'h01);
		wr(ctl, 8'h11);
		pulse(0);
		repeat (300) @(posedge ref_clk);
		rd(st, 9'h003, 9'h002);
		wait_uf(3000);
		rd(st, 9'h003, 9'h001);
		$display("rates done");
		test_done();
	end
endmodule // rtt_timer_two_bench

bind rtt_timer_two rtt_timer_two_assertions u_rtt_timer_two_assertions (
	.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tx_end(tx_end),
	.rx_first_nibble(rx_first_nibble),
	.underflow_irq_flag(underflow_irq_flag),
	.underflow_pulse(underflow_pulse), .timer_running(timer_running));
